// >>> sas_consts.svh
// constants for the successive-approximation converter sequencer
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH
`define SAS_RES_BITS      10
`define SAS_CHAN_BITS     4
`define SAS_CSR_DONE      7
`define SAS_CSR_SPEED     6
`define SAS_CSR_ON        5
`define SAS_CSR_RSVD      4
`define SAS_CSR_RESET     8'h00
`define SAS_RES_RESET     10'h000
`define SAS_RES_FULL      10'h3ff
`define SAS_RES_ZERO      10'h000
`define SAS_DIV_SLOW      3'h4
`define SAS_DIV_FAST      3'h2
`define SAS_SAMPLE_STEPS  4'h2
`endif

// >>> sas_pkg.sv
// types for the successive-approximation converter sequencer
package sas_pkg;
   typedef enum logic [1:0] {
      SAS_IDLE,
      SAS_SAMPLE,
      SAS_RESOLVE
   } sas_state_t;

   // software access to the three byte registers
   typedef struct packed {
      logic       csr_wr;
      logic [7:0] csr_wdata;
      logic       high_rd;
   } sas_host_t;

   // analogue front end controls
   typedef struct packed {
      logic       sample;
      logic [3:0] channel;
      logic [9:0] trial;
   } sas_afe_t;
endpackage

// >>> sas_sequencer.sv
// control logic of the 10-bit successive-approximation converter
`timescale 1ns/1ps
`include "sas_consts.svh"

module sas_sequencer
   import sas_pkg::*;
#(
   parameter int RES_BITS  = `SAS_RES_BITS,
   parameter int CHAN_BITS = `SAS_CHAN_BITS
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   input  wire sas_host_t  i_host,
   input  wire logic       i_cmp_above,
   input  wire logic [15:0] i_pin_level,
   output sas_afe_t        o_afe,
   output logic            o_afe_enable,
   output logic [7:0]      o_converter_control_status,
   output logic [7:0]      o_result_high_byte,
   output logic [7:0]      o_result_low_byte,
   output logic [15:0]     o_port_level
);

   initial begin
      if (RES_BITS != 10 || CHAN_BITS != 4) begin
         $error("sas_sequencer: only a 10-bit result and 4-bit channel field are supported");
      end
      // the comparator gets at least one whole clock to settle after a trial change
      if (`SAS_DIV_FAST < 3'h2 || `SAS_DIV_SLOW < `SAS_DIV_FAST) begin
         $error("sas_sequencer: dividers must be two or more, the slow one no faster");
      end
      if (`SAS_SAMPLE_STEPS == 4'h0) begin
         $error("sas_sequencer: at least one sample step is needed");
      end
   end

   logic                 converter_on_bit_r;
   logic                 speed_r;
   logic [3:0]           channel_select_bits_r;
   logic                 done_r;
   logic [9:0]           result_r;
   logic [9:0]           trial_r;
   logic [3:0]           bit_idx_r;
   logic [3:0]           sample_cnt_r;
   logic [2:0]           div_cnt_r;
   sas_state_t           state_r;
   logic [15:0]          pin_meta_r;
   logic [15:0]          pin_sync_r;
   logic                 step;
   logic                 restart;
   logic                 halt;
   logic                 finish;
   logic [2:0]           div_last;

   // pins are asynchronous to this clock: two flops before any use
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         pin_meta_r <= 16'h0000;
         pin_sync_r <= 16'h0000;
      end else begin
         pin_meta_r <= i_pin_level;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign o_port_level = pin_sync_r;

   assign restart = i_host.csr_wr && (i_host.csr_wdata[3:0] != channel_select_bits_r);

   // off write stops at once
   // acting on the write itself, not a clock later, keeps a completion or a
   // sampling phase from slipping out after software has switched off
   assign halt = restart || (i_host.csr_wr && !i_host.csr_wdata[`SAS_CSR_ON]);

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         converter_on_bit_r    <= 1'b0;
         speed_r               <= 1'b0;
         channel_select_bits_r <= 4'h0;
      end else if (i_host.csr_wr) begin
         // bit 7 and reserved bit 4 of a write are dropped
         // on bit written by software
         converter_on_bit_r    <= i_host.csr_wdata[`SAS_CSR_ON];
         speed_r               <= i_host.csr_wdata[`SAS_CSR_SPEED];
         channel_select_bits_r <= i_host.csr_wdata[3:0];
      end
   end

   assign div_last = speed_r ? (`SAS_DIV_FAST - 3'h1) : (`SAS_DIV_SLOW - 3'h1);

   // the divider restarts when the converter is switched on or the channel changes, so the first step is a full one
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         div_cnt_r <= 3'h0;
      end else if (!converter_on_bit_r || halt || div_cnt_r >= div_last) begin
         div_cnt_r <= 3'h0;
      end else begin
         div_cnt_r <= div_cnt_r + 3'h1;
      end
   end

   // first conversion after switching on: an idle step, two sample steps and ten
   // resolve steps; later conversions go straight back to sampling, so the
   // repeat period is twelve steps of four or two clocks, and one bit is
   // decided at every resolve step edge
   assign step   = converter_on_bit_r && !halt && (div_cnt_r >= div_last);
   assign finish = step && (state_r == SAS_RESOLVE) && (bit_idx_r == 4'h0);

   // the comparator is a latched stage strobed from this clock, so its decision
   // is read directly; two synchroniser flops would eat the whole bit time of
   // the fast divider and hand back the decision on the previous trial
   // sample then resolve msb first
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         state_r      <= SAS_IDLE;
         trial_r      <= `SAS_RES_RESET;
         bit_idx_r    <= 4'h0;
         sample_cnt_r <= 4'h0;
      end else if (!converter_on_bit_r || halt) begin
         state_r      <= SAS_IDLE;
         trial_r      <= `SAS_RES_RESET;
         bit_idx_r    <= 4'h0;
         sample_cnt_r <= 4'h0;
      end else if (step) begin
         unique case (state_r)
            SAS_IDLE: begin
               state_r      <= SAS_SAMPLE;
               sample_cnt_r <= 4'h0;
            end
            SAS_SAMPLE: begin
               if (sample_cnt_r == `SAS_SAMPLE_STEPS - 4'h1) begin
                  state_r   <= SAS_RESOLVE;
                  bit_idx_r <= 4'(RES_BITS - 1);
                  trial_r   <= 10'h200;
               end else begin
                  sample_cnt_r <= sample_cnt_r + 4'h1;
               end
            end
            SAS_RESOLVE: begin
               // keep bit if input above trial level; saturate naturally
               trial_r[bit_idx_r] <= i_cmp_above;
               if (bit_idx_r == 4'h0) begin
                  state_r <= SAS_SAMPLE;
                  sample_cnt_r <= 4'h0;
               end else begin
                  trial_r[bit_idx_r - 4'h1] <= 1'b1;
                  bit_idx_r <= bit_idx_r - 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         result_r <= `SAS_RES_RESET;
      end else if (finish) begin
         // load final result
         // an unread pair is simply replaced; software must keep up
         result_r <= {trial_r[9:1], i_cmp_above};
      end
   end

   // done flag: a completion in the same cycle as a clear wins
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         done_r <= 1'b0;
      end else if (finish) begin
         done_r <= 1'b1;
      end else if (i_host.csr_wr || i_host.high_rd) begin
         done_r <= 1'b0;
      end
   end

   assign o_afe.channel = channel_select_bits_r;
   assign o_afe.sample  = (state_r == SAS_SAMPLE);
   assign o_afe.trial   = trial_r;
   assign o_afe_enable  = converter_on_bit_r;

   // status byte from the field positions; reserved bit 4 reads zero
   always_comb begin
      o_converter_control_status                 = `SAS_CSR_RESET;
      o_converter_control_status[`SAS_CSR_DONE]  = done_r;
      o_converter_control_status[`SAS_CSR_SPEED] = speed_r;
      o_converter_control_status[`SAS_CSR_ON]    = converter_on_bit_r;
      o_converter_control_status[`SAS_CSR_RSVD]  = 1'b0;
      o_converter_control_status[3:0]            = channel_select_bits_r;
   end
   assign o_result_high_byte = result_r[9:2];
   assign o_result_low_byte  = {6'h00, result_r[1:0]};

endmodule

// >>> sas_afe_model.sv
// behavioural multiplexer and comparator for the converter front end
`timescale 1ns/1ps
module sas_afe_model
   import sas_pkg::*;
(
   input  wire logic     i_ref_clk,
   input  wire sas_afe_t i_afe,
   input  wire logic     i_enable,
   input  var  int       i_level [16],
   output logic          o_cmp_above
);
   logic last_r = 1'b0;
   always @(posedge i_ref_clk) last_r <= o_cmp_above;
   assign o_cmp_above = i_enable ? (i_level[i_afe.channel] > int'(i_afe.trial)) : ~last_r;
endmodule

// >>> sas_sequencer_assertions.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
module sas_sequencer_assertions
   import sas_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   input wire sas_host_t   i_host,
   input wire logic [15:0] i_pin_level,
   input wire sas_afe_t    o_afe,
   input wire logic        o_afe_enable,
   input wire logic [7:0]  o_converter_control_status,
   input wire logic [7:0]  o_result_low_byte,
   input wire logic [15:0] o_port_level
);
   logic [7:0] wd_r;
   logic [7:0] cs;
   assign cs = o_converter_control_status;
   always_ff @(posedge i_ref_clk) wd_r <= i_host.csr_wdata;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   property p_low_zero; o_result_low_byte[7:2] == 6'h00; endproperty
   a_low_zero: assert property (p_low_zero) else $error("low byte upper bits set");
   property p_wr_fields; i_host.csr_wr |=> cs[6:0] == {wd_r[6:5], 1'b0, wd_r[3:0]}; endproperty
   a_wr_fields: assert property (p_wr_fields) else $error("status fields wrong after write");
   property p_wr_done; i_host.csr_wr |=> !cs[7] || o_afe.sample; endproperty
   a_wr_done: assert property (p_wr_done) else $error("done kept after write");
   property p_rd_done; i_host.high_rd |=> !cs[7] || o_afe.sample; endproperty
   a_rd_done: assert property (p_rd_done) else $error("done kept after high read");
   property p_chan; o_afe.channel == cs[3:0]; endproperty
   a_chan: assert property (p_chan) else $error("mux channel differs from field");
   property p_enable; o_afe_enable == cs[5]; endproperty
   a_enable: assert property (p_enable) else $error("enable differs from on bit");
   property p_off; !o_afe_enable |-> !o_afe.sample && !$rose(cs[7]); endproperty
   a_off: assert property (p_off) else $error("activity while off");
   property p_abort; i_host.csr_wr && i_host.csr_wdata[5] && cs[5] && i_host.csr_wdata[3:0] != cs[3:0]
      |-> ##[1:6] o_afe.sample; endproperty
   a_abort: assert property (p_abort) else $error("no restart on channel change");
   property p_port; o_port_level == $past(i_pin_level, 2); endproperty
   a_port: assert property (p_port) else $error("port level not passed on");
endmodule
bind sas_sequencer sas_sequencer_assertions u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_host(i_host),
   .i_pin_level(i_pin_level), .o_afe(o_afe), .o_afe_enable(o_afe_enable),
   .o_converter_control_status(o_converter_control_status), .o_result_low_byte(o_result_low_byte),
   .o_port_level(o_port_level));

// >>> sar_adc_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
   import sas_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   sas_host_t   host = '0;
   logic [15:0] pins = 16'h0000;
   logic        cmp, en;
   sas_afe_t    afe;
   logic [7:0]  cs, hi, lo;
   logic [15:0] port;
   int          lvl [16];
   int          n_errors = 0, n_compared = 0, cyc = 0;
   sas_sequencer dut (.i_ref_clk(clk), .i_reset(rst), .i_host(host), .i_cmp_above(cmp), .i_pin_level(pins),
      .o_afe(afe), .o_afe_enable(en), .o_converter_control_status(cs), .o_result_high_byte(hi),
      .o_result_low_byte(lo), .o_port_level(port));
   sas_afe_model afe_m (.i_ref_clk(clk), .i_afe(afe), .i_enable(en), .i_level(lvl), .o_cmp_above(cmp));
   initial forever #2.5 clk = ~clk;
   task wrap_up;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // runaway guard, far above the expected run of under two thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         wrap_up();
      end
   end
   task chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task csr_write(logic [7:0] d);
      @(negedge clk) host.csr_wr = 1'b1;
      host.csr_wdata = d;
      @(negedge clk) host.csr_wr = 1'b0;
   endtask
   task read_high;
      @(negedge clk) host.high_rd = 1'b1;
      @(negedge clk) host.high_rd = 1'b0;
   endtask
   task wait_done;
      int k;
      k = 0;
      while (cs[7] !== 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      chk("done", cs[7], 1'b1);
   endtask
   task check_result(int ch);
      int c;
      c = lvl[ch] > 1023 ? 1023 : (lvl[ch] < 1 ? 0 : lvl[ch] - 1);
      chk("low", lo, {14'h0, c[1:0]});
      chk("high", hi, 16'(c[9:2]));
   endtask
   initial begin
      void'($urandom(11610));
      foreach (lvl[i]) lvl[i] = 0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      chk("reset", {cs, hi | lo}, 16'h0000);
      for (int i = 0; i < 16; i++) begin
         lvl[i] = (i == 0) ? 0 : (i == 1) ? 1100 : int'($urandom_range(1, 1023));
         pins = 16'($urandom);
         csr_write({1'b0, 1'($urandom_range(0, 1)), 2'b10, 4'(i)});
         wait_done();
         check_result(i);
         chk("port", port, pins);
         read_high();
         chk("done clear", cs[7], 1'b0);
      end
      lvl[15] = 512;
      repeat (2) begin
         read_high();
         wait_done();
      end
      check_result(15);
      lvl[15] = 700;
      repeat (130) @(negedge clk);
      chk("done held", cs[7], 1'b1);
      check_result(15);
      csr_write(8'h23);
      wait_done();
      check_result(3);
      repeat (20) @(negedge clk);
      csr_write(8'h65);
      chk("abort done", cs[7], 1'b0);
      wait_done();
      check_result(5);
      csr_write(8'h05);
      repeat (150) @(negedge clk);
      chk("off", {cs[7], en, afe.sample}, 16'h0000);
      wrap_up();
   end
endmodule
